// [rtl/dtc_pkg.sv]
package dtc_pkg;
  // ==========================================================
  // register addresses
  localparam logic [7:0] DTC_ADDR_CTRL = 8'h88;
  localparam logic [7:0] DTC_ADDR_MODE = 8'h89;
  localparam logic [7:0] DTC_ADDR_A_LO = 8'h8a;
  localparam logic [7:0] DTC_ADDR_B_LO = 8'h8b;
  localparam logic [7:0] DTC_ADDR_A_HI = 8'h8c;
  localparam logic [7:0] DTC_ADDR_B_HI = 8'h8d;
  // ==========================================================
  // reset values
  localparam logic [7:0] DTC_RST_CTRL = 8'h00;
  localparam logic [7:0] DTC_RST_MODE = 8'h00;
  localparam logic [7:0] DTC_RST_DATA = 8'h00;
  // ==========================================================
  // timer_control_flags bit positions
  localparam int DTC_TF_B = 7;
  localparam int DTC_TR_B = 6;
  localparam int DTC_TF_A = 5;
  localparam int DTC_TR_A = 4;
  localparam int DTC_IE_B = 3;
  localparam int DTC_IT_B = 2;
  localparam int DTC_IE_A = 1;
  localparam int DTC_IT_A = 0;
  // ==========================================================
  // timer_mode_select bit positions
  localparam int DTC_GATE_B = 7;
  localparam int DTC_CT_B = 6;
  localparam int DTC_MODE_B_LSB = 4;
  localparam int DTC_GATE_A = 3;
  localparam int DTC_CT_A = 2;
  localparam int DTC_MODE_A_LSB = 0;
  // ==========================================================
  // timing
  localparam int DTC_TIMER_DIV_CYCLES = 2;
  localparam int DTC_PRESCALE_BITS = 5;
  // ==========================================================
  // operating modes
  typedef enum logic [1:0] {
    DTC_MODE_PRESCALE = 2'b00,
    DTC_MODE_WIDE = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT = 2'b11
  } dtc_mode_e;
endpackage

// [rtl/dtc_timer.sv]
`timescale 1ns/10ps
module dtc_timer (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic timer_a_irq_ack,
  input wire logic timer_b_irq_ack,
  input wire logic ext_irq_a_ack,
  input wire logic ext_irq_b_ack,
  input wire logic ext_irq_a_pin,
  input wire logic ext_irq_b_pin,
  input wire logic timer_a_count_pin,
  input wire logic timer_b_count_pin,
  input wire logic rfc_prescaled_clk,
  input wire logic timer_a_count_source_select,
  output logic timer_a_irq,
  output logic timer_b_irq,
  output logic ext_irq_a_irq,
  output logic ext_irq_b_irq
);
  // ==========================================================
  // one step of a counter: {overflow, high, low}
  function automatic logic [16:0] dtc_step(input dtc_pkg::dtc_mode_e mode, input logic [7:0] lo,
                                           input logic [7:0] hi, input logic tick);
    logic [8:0] s;
    logic [16:0] r;
    s = 9'h000;
    r = {1'b0, hi, lo};
    if (tick) begin
      case (mode)
        dtc_pkg::DTC_MODE_PRESCALE: begin
          if (lo[dtc_pkg::DTC_PRESCALE_BITS-1:0] == 5'h1f) begin
            s = {1'b0, hi} + 9'h001;
            r = {s[8], s[7:0], lo[7:5], 5'h00};
          end else begin
            r = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
          end
        end
        dtc_pkg::DTC_MODE_WIDE: begin
          r = {1'b0, hi, lo} + 17'h00001;
        end
        dtc_pkg::DTC_MODE_RELOAD: begin
          s = {1'b0, lo} + 9'h001;
          r = s[8] ? {1'b1, hi, hi} : {1'b0, hi, s[7:0]};
        end
        default: begin
          s = {1'b0, lo} + 9'h001;
          r = {s[8], hi, s[7:0]};
        end
      endcase
    end
    return r;
  endfunction

  logic [7:0] ctrl;
  logic [7:0] timer_mode_select;
  logic [7:0] a_lo;
  logic [7:0] a_hi;
  logic [7:0] b_lo;
  logic [7:0] b_hi;
  logic [7:0] next_ctrl;

  // ==========================================================
  // pin synchronisers and falling-edge detect
  logic [4:0] pin_in;
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic [4:0] prev;
  logic [4:0] fall;
  assign pin_in = {rfc_prescaled_clk, timer_b_count_pin, timer_a_count_pin, ext_irq_b_pin, ext_irq_a_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          sync1[gi] <= 1'b1;
          sync2[gi] <= 1'b1;
          prev[gi] <= 1'b1;
        end else begin
          sync1[gi] <= pin_in[gi];
          sync2[gi] <= sync1[gi];
          prev[gi] <= sync2[gi];
        end
      end
      assign fall[gi] = prev[gi] & ~sync2[gi];
    end
  endgenerate

  logic irq_a_s;
  logic irq_b_s;
  assign irq_a_s = sync2[0];
  assign irq_b_s = sync2[1];

  // ==========================================================
  // system tick every two clocks
  logic sys_tick;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sys_tick <= 1'b0;
    end else begin
      sys_tick <= ~sys_tick;
    end
  end

  // ==========================================================
  // write strobes
  logic wr_ctrl;
  logic wr_mode;
  logic wr_a_lo;
  logic wr_a_hi;
  logic wr_b_lo;
  logic wr_b_hi;
  assign wr_ctrl = sfr_wr && (sfr_addr == dtc_pkg::DTC_ADDR_CTRL);
  assign wr_mode = sfr_wr && (sfr_addr == dtc_pkg::DTC_ADDR_MODE);
  assign wr_a_lo = sfr_wr && (sfr_addr == dtc_pkg::DTC_ADDR_A_LO);
  assign wr_a_hi = sfr_wr && (sfr_addr == dtc_pkg::DTC_ADDR_A_HI);
  assign wr_b_lo = sfr_wr && (sfr_addr == dtc_pkg::DTC_ADDR_B_LO);
  assign wr_b_hi = sfr_wr && (sfr_addr == dtc_pkg::DTC_ADDR_B_HI);

  // ==========================================================
  // count enables
  dtc_pkg::dtc_mode_e mode_a;
  dtc_pkg::dtc_mode_e mode_b;
  assign mode_a = dtc_pkg::dtc_mode_e'(timer_mode_select[dtc_pkg::DTC_MODE_A_LSB +: 2]);
  assign mode_b = dtc_pkg::dtc_mode_e'(timer_mode_select[dtc_pkg::DTC_MODE_B_LSB +: 2]);

  logic run_a;
  logic run_b;
  logic en_a;
  logic en_b;
  logic src_a;
  logic tick_a;
  logic tick_b;
  logic tick_ah;
  assign run_a = ctrl[dtc_pkg::DTC_TR_A];
  assign run_b = ctrl[dtc_pkg::DTC_TR_B];
  assign en_a = run_a && (!timer_mode_select[dtc_pkg::DTC_GATE_A] || irq_a_s);
  assign en_b = run_b && (!timer_mode_select[dtc_pkg::DTC_GATE_B] || irq_b_s);
  assign src_a = timer_a_count_source_select ? fall[4] : fall[2];
  assign tick_a = en_a && (timer_mode_select[dtc_pkg::DTC_CT_A] ? src_a : sys_tick);
  assign tick_b = en_b && (mode_b != dtc_pkg::DTC_MODE_SPLIT)
                  && (timer_mode_select[dtc_pkg::DTC_CT_B] ? fall[3] : sys_tick);
  assign tick_ah = run_b && sys_tick && (mode_a == dtc_pkg::DTC_MODE_SPLIT);

  logic [16:0] step_a;
  logic [16:0] step_b;
  logic [8:0] step_ah;
  logic ovf_a;
  logic ovf_b;
  assign step_a = dtc_step(mode_a, a_lo, a_hi, tick_a);
  assign step_b = dtc_step(mode_b, b_lo, b_hi, tick_b);
  assign step_ah = {1'b0, a_hi} + {8'h00, tick_ah};
  assign ovf_a = step_a[16];
  assign ovf_b = (mode_a == dtc_pkg::DTC_MODE_SPLIT) ? step_ah[8] : step_b[16];

  logic set_ea;
  logic set_eb;
  assign set_ea = ctrl[dtc_pkg::DTC_IT_A] ? fall[0] : ~irq_a_s;
  assign set_eb = ctrl[dtc_pkg::DTC_IT_B] ? fall[1] : ~irq_b_s;

  // ==========================================================
  // control and flags, hardware set wins
  always_comb begin
    next_ctrl = wr_ctrl ? sfr_wdata : ctrl;
    if (timer_b_irq_ack) next_ctrl[dtc_pkg::DTC_TF_B] = 1'b0;
    if (timer_a_irq_ack) next_ctrl[dtc_pkg::DTC_TF_A] = 1'b0;
    if (ext_irq_b_ack) next_ctrl[dtc_pkg::DTC_IE_B] = 1'b0;
    if (ext_irq_a_ack) next_ctrl[dtc_pkg::DTC_IE_A] = 1'b0;
    if (ovf_b) next_ctrl[dtc_pkg::DTC_TF_B] = 1'b1;
    if (ovf_a) next_ctrl[dtc_pkg::DTC_TF_A] = 1'b1;
    if (set_eb) next_ctrl[dtc_pkg::DTC_IE_B] = 1'b1;
    if (set_ea) next_ctrl[dtc_pkg::DTC_IE_A] = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= dtc_pkg::DTC_RST_CTRL;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      timer_mode_select <= dtc_pkg::DTC_RST_MODE;
    end else if (wr_mode) begin
      timer_mode_select <= sfr_wdata;
    end
  end

  // ==========================================================
  // data bytes, software write wins over counting
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      a_lo <= dtc_pkg::DTC_RST_DATA;
      a_hi <= dtc_pkg::DTC_RST_DATA;
    end else begin
      a_lo <= wr_a_lo ? sfr_wdata : step_a[7:0];
      if (wr_a_hi) begin
        a_hi <= sfr_wdata;
      end else if (mode_a == dtc_pkg::DTC_MODE_SPLIT) begin
        a_hi <= step_ah[7:0];
      end else begin
        a_hi <= step_a[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      b_lo <= dtc_pkg::DTC_RST_DATA;
      b_hi <= dtc_pkg::DTC_RST_DATA;
    end else begin
      b_lo <= wr_b_lo ? sfr_wdata : step_b[7:0];
      b_hi <= wr_b_hi ? sfr_wdata : step_b[15:8];
    end
  end

  // ==========================================================
  // read port, one cycle latency
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      if (sfr_addr == dtc_pkg::DTC_ADDR_CTRL) begin
        sfr_rdata <= ctrl;
      end else if (sfr_addr == dtc_pkg::DTC_ADDR_MODE) begin
        sfr_rdata <= timer_mode_select;
      end else if (sfr_addr == dtc_pkg::DTC_ADDR_A_LO) begin
        sfr_rdata <= a_lo;
      end else if (sfr_addr == dtc_pkg::DTC_ADDR_B_LO) begin
        sfr_rdata <= b_lo;
      end else if (sfr_addr == dtc_pkg::DTC_ADDR_A_HI) begin
        sfr_rdata <= a_hi;
      end else if (sfr_addr == dtc_pkg::DTC_ADDR_B_HI) begin
        sfr_rdata <= b_hi;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  assign timer_a_irq = ctrl[dtc_pkg::DTC_TF_A];
  assign timer_b_irq = ctrl[dtc_pkg::DTC_TF_B];
  assign ext_irq_a_irq = ctrl[dtc_pkg::DTC_IE_A];
  assign ext_irq_b_irq = ctrl[dtc_pkg::DTC_IE_B];

  // ==========================================================
  // assertions
  a_ovf_b_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    ovf_b |=> timer_b_irq) else $error("timer b overflow did not set flag");
  a_ovf_a_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    ovf_a |=> timer_a_irq) else $error("timer a overflow did not set flag");
  a_ack_a_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    timer_a_irq_ack && !ovf_a && !wr_ctrl |=> !timer_a_irq) else $error("ack did not clear flag");
  a_stopped_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    !run_a && !wr_a_lo |=> $stable(a_lo)) else $error("stopped timer a changed");
  a_gate_block: assert property (@(posedge ref_clk) disable iff (!rstn)
    timer_mode_select[dtc_pkg::DTC_GATE_A] && !irq_a_s |-> !tick_a) else $error("gated timer counted");
  a_ext_b_edge: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrl[dtc_pkg::DTC_IT_B] && fall[1] |=> ext_irq_b_irq) else $error("edge did not set ext b");
  a_ext_a_level: assert property (@(posedge ref_clk) disable iff (!rstn)
    !ctrl[dtc_pkg::DTC_IT_A] && !irq_a_s |=> ext_irq_a_irq) else $error("low level did not set ext a");
  a_sys_tick_rate: assert property (@(posedge ref_clk) disable iff (!rstn)
    (mode_a == dtc_pkg::DTC_MODE_WIDE && !timer_mode_select[dtc_pkg::DTC_CT_A] && en_a && !wr_a_lo && !wr_a_hi && !wr_mode
    && !wr_ctrl) ##1 (en_a && !wr_a_lo && !wr_a_hi && !wr_ctrl)
    |=> a_lo == $past(a_lo, 2) + 8'h01) else $error("timer a not one count per 2 clocks");
  a_reload_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    mode_a == dtc_pkg::DTC_MODE_RELOAD && tick_a && a_lo == 8'hff && !wr_a_lo && !wr_a_hi
    |=> a_lo == $past(a_hi) && $stable(a_hi)) else $error("reload failed");
  a_wide_wrap: assert property (@(posedge ref_clk) disable iff (!rstn)
    mode_a == dtc_pkg::DTC_MODE_WIDE && tick_a && {a_hi, a_lo} == 16'hffff && !wr_a_lo && !wr_a_hi
    |-> ovf_a ##1 (a_lo == 8'h00 && a_hi == 8'h00)) else $error("16-bit wrap failed");
  a_b_split_stop: assert property (@(posedge ref_clk) disable iff (!rstn)
    mode_b == dtc_pkg::DTC_MODE_SPLIT && !wr_b_lo && !wr_b_hi |=> $stable(b_lo) && $stable(b_hi))
    else $error("timer b counted in mode 11");
  a_split_high: assert property (@(posedge ref_clk) disable iff (!rstn)
    mode_a == dtc_pkg::DTC_MODE_SPLIT && tick_ah && a_hi == 8'hff && !wr_a_hi
    |=> timer_b_irq && a_hi == 8'h00) else $error("split high byte overflow failed");
  a_edge_once: assert property (@(posedge ref_clk) disable iff (!rstn)
    mode_a == dtc_pkg::DTC_MODE_WIDE && timer_mode_select[dtc_pkg::DTC_CT_A] && !timer_a_count_source_select && en_a
    && !wr_a_lo && !wr_a_hi |=> a_lo == $past(a_lo) + {7'h00, $past(fall[2])})
    else $error("count pin edge not counted once");
endmodule

// [tb/dtc_pin_model.sv]
`timescale 1ns/10ps
module dtc_pin_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic [7:0] edges,
  output logic pin,
  output logic busy
);
  // ==========================================================
  // falling-edge burst, each level held three clocks
  logic [7:0] left;
  logic [2:0] ph;
  assign busy = (left != 8'h00);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      left <= 8'h00;
      ph <= 3'h0;
      pin <= 1'b1;
    end else if (go) begin
      left <= edges;
      ph <= 3'h0;
    end else if (busy) begin
      ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      pin <= (ph < 3'h3) ? 1'b0 : 1'b1;
      if (ph == 3'h5) begin
        left <= left - 8'h01;
      end
    end
  end
endmodule

// [tb/dual_timer_counter_tb.sv]
`timescale 1ns/10ps
module dual_timer_counter_tb;
  logic ref_clk, rstn, wr_s, rd_s, sel;
  logic [7:0] addr, wd, rdata, eg;
  logic [3:0] ack;
  logic [1:0] xp;
  logic [2:0] go, busy, cp;
  wire [3:0] irq;
  int failures, compares, cyc;
  dtc_timer u_dtc_timer (.ref_clk(ref_clk), .rstn(rstn), .sfr_addr(addr), .sfr_wr(wr_s), .sfr_rd(rd_s),
    .sfr_wdata(wd), .sfr_rdata(rdata), .timer_a_irq_ack(ack[0]), .timer_b_irq_ack(ack[1]),
    .ext_irq_a_ack(ack[2]), .ext_irq_b_ack(ack[3]), .ext_irq_a_pin(xp[0]), .ext_irq_b_pin(xp[1]),
    .timer_a_count_pin(cp[0]), .timer_b_count_pin(cp[2]), .rfc_prescaled_clk(cp[1]),
    .timer_a_count_source_select(sel), .timer_a_irq(irq[0]), .timer_b_irq(irq[1]),
    .ext_irq_a_irq(irq[2]), .ext_irq_b_irq(irq[3]));
  dtc_pin_model u_dtc_pin_model_a (.ref_clk(ref_clk), .rstn(rstn), .go(go[0]), .edges(eg), .pin(cp[0]),
    .busy(busy[0]));
  dtc_pin_model u_dtc_pin_model_r (.ref_clk(ref_clk), .rstn(rstn), .go(go[1]), .edges(eg), .pin(cp[1]),
    .busy(busy[1]));
  dtc_pin_model u_dtc_pin_model_b (.ref_clk(ref_clk), .rstn(rstn), .go(go[2]), .edges(eg), .pin(cp[2]),
    .busy(busy[2]));
  // ==========================================================
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr_s <= 1'b1;
    @(posedge ref_clk);
    wr_s <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk);
    rd_s <= 1'b0;
    @(posedge ref_clk);
    chk(rdata & m, e);
  endtask
  task automatic wirq(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (irq[i] !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    chk({7'h00, irq[i]}, {7'h00, v});
  endtask
  task automatic give_ack(input int i);
    ack[i] <= 1'b1;
    @(posedge ref_clk);
    ack[i] <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic burst(input int w, input logic [7:0] n);
    int k;
    k = 0;
    eg <= n;
    go[w] <= 1'b1;
    @(posedge ref_clk);
    go[w] <= 1'b0;
    @(posedge ref_clk);
    while (busy[w] && k < 200) begin
      @(posedge ref_clk);
      k++;
    end
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================
  // clock, reset, timeout
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end
  // ==========================================================
  // tests
  initial begin
    {rstn, wr_s, rd_s, sel, addr, wd, eg, ack, go} = '0;
    xp = 2'b11;
    failures = 0;
    compares = 0;
    cyc = 0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 6; i++) rd(8'h88 + 8'(i), 8'hff, 8'h00);
    rd(8'h90, 8'hff, 8'h00);
    for (int i = 0; i < 4; i++) wr(8'h8a + 8'(i), 8'h11 * 8'(i + 1));
    for (int i = 0; i < 4; i++) rd(8'h8a + 8'(i), 8'hff, 8'h11 * 8'(i + 1));
    done("registers");
    wr(8'h89, 8'h01);
    wr(8'h8c, 8'hff);
    wr(8'h8a, 8'hf0);
    wr(8'h88, 8'h10);
    wirq(0, 1'b1, 60);
    wr(8'h88, 8'h20);
    rd(8'h8c, 8'hff, 8'h00);
    give_ack(0);
    wirq(0, 1'b0, 0);
    wr(8'h8a, 8'h55);
    repeat (10) @(posedge ref_clk);
    rd(8'h8a, 8'hff, 8'h55);
    done("wide");
    wr(8'h89, 8'h00);
    wr(8'h8c, 8'h05);
    wr(8'h8a, 8'hff);
    wr(8'h88, 8'h10);
    wr(8'h88, 8'h00);
    rd(8'h8c, 8'hff, 8'h06);
    rd(8'h8a, 8'hff, 8'he0);
    done("prescale");
    wr(8'h89, 8'h20);
    wr(8'h8d, 8'hf0);
    wr(8'h8b, 8'hfe);
    wr(8'h88, 8'h40);
    wirq(1, 1'b1, 40);
    wr(8'h88, 8'h80);
    rd(8'h8d, 8'hff, 8'hf0);
    rd(8'h8b, 8'hf0, 8'hf0);
    give_ack(1);
    wirq(1, 1'b0, 0);
    done("reload");
    wr(8'h89, 8'h33);
    wr(8'h8b, 8'h10);
    wr(8'h8c, 8'hfe);
    wr(8'h88, 8'h40);
    wirq(1, 1'b1, 20);
    rd(8'h8b, 8'hff, 8'h10);
    rd(8'h8a, 8'hff, 8'he0);
    wr(8'h88, 8'h80);
    give_ack(1);
    done("split");
    wr(8'h89, 8'h02);
    wr(8'h8c, 8'h06);
    wr(8'h8a, 8'hfe);
    wr(8'h88, 8'h10);
    wirq(0, 1'b1, 40);
    wr(8'h88, 8'h20);
    rd(8'h8c, 8'hff, 8'h06);
    rd(8'h8a, 8'hff, 8'h07);
    give_ack(0);
    done("reload a");
    wr(8'h89, 8'h05);
    wr(8'h8a, 8'h00);
    wr(8'h88, 8'h10);
    burst(0, 8'h05);
    rd(8'h8a, 8'hff, 8'h05);
    wr(8'h89, 8'h0d);
    xp[0] <= 1'b0;
    burst(0, 8'h03);
    rd(8'h8a, 8'hff, 8'h05);
    xp[0] <= 1'b1;
    burst(0, 8'h02);
    rd(8'h8a, 8'hff, 8'h07);
    sel <= 1'b1;
    burst(0, 8'h02);
    burst(1, 8'h03);
    rd(8'h8a, 8'hff, 8'h0a);
    wr(8'h89, 8'h50);
    wr(8'h8b, 8'h00);
    wr(8'h88, 8'h40);
    burst(2, 8'h03);
    rd(8'h8b, 8'hff, 8'h03);
    done("counter");
    for (int i = 0; i < 2; i++) begin
      wr(8'h88, 8'h05);
      give_ack(2 + i);
      xp[i] <= 1'b0;
      wirq(2 + i, 1'b1, 8);
      give_ack(2 + i);
      repeat (3) @(posedge ref_clk);
      wirq(2 + i, 1'b0, 0);
      xp[i] <= 1'b1;
      repeat (3) @(posedge ref_clk);
      wr(8'h88, 8'h00);
      wirq(2 + i, 1'b0, 0);
      xp[i] <= 1'b0;
      wirq(2 + i, 1'b1, 8);
      give_ack(2 + i);
      wirq(2 + i, 1'b1, 0);
      xp[i] <= 1'b1;
      repeat (4) @(posedge ref_clk);
      give_ack(2 + i);
      wirq(2 + i, 1'b0, 0);
    end
    done("external");
    give_verdict();
  end
endmodule
